// >>> swbpc_pacer.sv
// per-queue egress byte pacer
// assumes byte_sent is a one-cycle pulse on clk from the egress logic
`timescale 1ns/10ps
`default_nettype none
`include "swbpc_regs.svh"

module swbpc_pacer (
	input  wire logic        clk,		// 100 mhz core clock
	input  wire logic        rst_b,		// async reset, active low
	input  wire logic [12:0] rate,		// bytes interval code
	input  wire logic        enable,	// pacing on for this queue
	input  wire logic        byte_sent,	// one byte left the queue
	output logic             may_send	// next byte allowed
);

	logic [14:0] cnt_q;	// cycles left in interval
	logic [14:0] cnt_d;
	logic [14:0] load;	// interval length minus one
	logic        may_d;

	// interval is (rate + 1) units of 20 ns, counted in clocks
	assign load = 15'((16'(rate) + 16'd1) * 16'(`SWBPC_PACE_UNIT_CYC)
		- 16'd1);	// [R2]

	// countdown after each byte, free when disabled
	always_comb begin
		if (!enable) begin
			cnt_d = '0;			// pacing off: no wait [R3]
		end else if (byte_sent) begin
			cnt_d = load;		// restart interval [R2]
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 15'd1;
		end else begin
			cnt_d = cnt_q;
		end
		may_d = (cnt_d == '0);
	end

	// state registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q    <= '0;
			may_send <= 1'b1;
		end else begin
			cnt_q    <= cnt_d;
			may_send <= may_d;
		end
	end

endmodule // swbpc_pacer
`default_nettype wire

// >>> swbpc_pkg.sv
// types shared by the port configuration register bank
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package swbpc_pkg;

	// default tag of one port
	typedef struct packed {
		logic [2:0]  prio;	// priority for inserted or changed tags
		logic [11:0] vid;	// vlan id for inserted or changed tags
	} swbpc_tag_t;

	// two 13-bit queue rate fields of one register
	typedef struct packed {
		logic [12:0] hi;	// odd queue
		logic [12:0] lo;	// even queue
	} swbpc_rate_pair_t;

	// register selected by an address
	typedef enum {
		SWBPC_SEL_Q01,
		SWBPC_SEL_Q23,
		SWBPC_SEL_TAG0,
		SWBPC_SEL_TAG1,
		SWBPC_SEL_TAG2,
		SWBPC_SEL_DROP0,
		SWBPC_SEL_DROP1,
		SWBPC_SEL_DROP2,
		SWBPC_SEL_NONE
	} swbpc_sel_t;

endpackage
`default_nettype wire

// >>> swbpc_port_cfg.sv
// port config bank: port 2 egress pacing, default tags, drop counters
// assumes axi4-lite master on clk; drop pulses and byte pulses on clk
//
// Operation
// R1 - port 2 queue rates, 13 bits each
// R2 - interval is (rate plus one) times 20 ns
// R3 - pacing also gated by configuration enables
// R4 - per port 3-bit default tag priority
// R5 - per port 12-bit default vlan id
// R6 - count red and yellow ingress rate drops
// R7 - counter read returns value then clears
// R8 - counter saturates at all ones
// R9 - reserved bits zero, everything resets zero
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "swbpc_regs.svh"

module swbpc_port_cfg (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	// axi4-lite write address
	input  wire logic [15:0]                   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// axi4-lite read address
	input  wire logic [15:0]                   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// port 2 egress pacing
	input  wire logic [3:0]                    p2_pace_enable,
	input  wire logic [3:0]                    p2_byte_sent,
	output logic [3:0]                         p2_may_send,
	// default tags, index is port number
	output swbpc_pkg::swbpc_tag_t [2:0]        port_default_tag,
	// ingress rate drops, index is port number
	input  wire logic [2:0]                    red_drop,
	input  wire logic [2:0]                    yellow_drop
);

	////////////////////////////////////////////////////////////////////
	// storage

	swbpc_pkg::swbpc_rate_pair_t q01_q;	// queues 0 and 1
	swbpc_pkg::swbpc_rate_pair_t q23_q;	// queues 2 and 3
	swbpc_pkg::swbpc_rate_pair_t q01_d;
	swbpc_pkg::swbpc_rate_pair_t q23_d;
	swbpc_pkg::swbpc_tag_t [2:0] tag_q;	// default tags
	swbpc_pkg::swbpc_tag_t [2:0] tag_d;
	logic [2:0][31:0]            drop_q;	// drop counters
	logic [2:0][31:0]            drop_d;

	////////////////////////////////////////////////////////////////////
	// bus handshake state

	logic aw_hs;		// write address taken
	logic w_hs;		// write data taken
	logic b_hs;		// write response taken
	logic ar_hs;		// read address taken
	logic r_hs;		// read data taken
	logic do_write;		// both halves held, commit now
	logic [15:0] awaddr_q;	// held write address
	logic [31:0] wdata_q;	// held write data
	logic [3:0]  wstrb_q;	// held byte enables

	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs  = s_axi_wvalid & s_axi_wready;
	assign b_hs  = s_axi_bvalid & s_axi_bready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign r_hs  = s_axi_rvalid & s_axi_rready;

	// one write and one read may be open at a time, each on its own.
	// awready and wready fall at their own handshake and rise again only
	// with the write response, so no second write can slip in between
	// the commit and its answer; arready does the same for reads.
	// nothing beyond the single open transfer is buffered.
	// ready low means that channel's item is held
	assign do_write = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;

	////////////////////////////////////////////////////////////////////
	// address decode

	swbpc_pkg::swbpc_sel_t wsel;	// register written
	swbpc_pkg::swbpc_sel_t rsel;	// register read

	// map a word index to a register
	function automatic swbpc_pkg::swbpc_sel_t dec(input logic [13:0] idx);
		case (idx)
			`SWBPC_IDX_P2_Q01_RATE: dec = swbpc_pkg::SWBPC_SEL_Q01;
			`SWBPC_IDX_P2_Q23_RATE: dec = swbpc_pkg::SWBPC_SEL_Q23;
			`SWBPC_IDX_HOST_TAG:    dec = swbpc_pkg::SWBPC_SEL_TAG0;
			`SWBPC_IDX_P1_TAG:      dec = swbpc_pkg::SWBPC_SEL_TAG1;
			`SWBPC_IDX_P2_TAG:      dec = swbpc_pkg::SWBPC_SEL_TAG2;
			`SWBPC_IDX_HOST_DROP:   dec = swbpc_pkg::SWBPC_SEL_DROP0;
			`SWBPC_IDX_P1_DROP:     dec = swbpc_pkg::SWBPC_SEL_DROP1;
			`SWBPC_IDX_P2_DROP:     dec = swbpc_pkg::SWBPC_SEL_DROP2;
			default:                dec = swbpc_pkg::SWBPC_SEL_NONE;
		endcase
	endfunction

	// only the word index takes part; the two low address bits are
	// ignored, so an unaligned address reaches the word that holds it.
	// anything outside the eight words is answered with an error.
	assign wsel = dec(awaddr_q[15:2]);
	assign rsel = dec(s_axi_araddr[15:2]);

	////////////////////////////////////////////////////////////////////
	// write data merge under byte enables

	logic [31:0] bmask;	// bit mask from strobes
	logic [31:0] old_w;	// current word of written register
	logic [31:0] new_w;	// word after merge

	assign bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	// current contents as software sees them
	always_comb begin
		case (wsel)
			swbpc_pkg::SWBPC_SEL_Q01:  old_w = {6'h00, q01_q};
			swbpc_pkg::SWBPC_SEL_Q23:  old_w = {6'h00, q23_q};
			swbpc_pkg::SWBPC_SEL_TAG0: old_w = {17'h0_0000, tag_q[0]};
			swbpc_pkg::SWBPC_SEL_TAG1: old_w = {17'h0_0000, tag_q[1]};
			swbpc_pkg::SWBPC_SEL_TAG2: old_w = {17'h0_0000, tag_q[2]};
			default:                   old_w = 32'h0000_0000;
		endcase
	end

	// merging starts from what software would read back, so bytes not strobed keep
	// their value; reserved bits are dropped when the fields are stored and never reach a register;
	// counters read as zero here and a write to them changes nothing.
	assign new_w = (old_w & ~bmask) | (wdata_q & bmask);

	// unmapped writes get an error answer
	logic wr_bad;
	assign wr_bad = (wsel == swbpc_pkg::SWBPC_SEL_NONE);

	////////////////////////////////////////////////////////////////////
	// configuration next values

	logic wr_q01;
	logic wr_q23;
	assign wr_q01 = do_write & (wsel == swbpc_pkg::SWBPC_SEL_Q01);
	assign wr_q23 = do_write & (wsel == swbpc_pkg::SWBPC_SEL_Q23);

	// fields change only in the single commit cycle; otherwise each
	// register takes back its own value, so all of them run every clock.
	// only bits 25:0 stored; upper bits dropped [R9]
	assign q01_d = wr_q01 ? {new_w[`SWBPC_RATE_HI_MSB:`SWBPC_RATE_HI_LSB],
		new_w[`SWBPC_RATE_LO_MSB:`SWBPC_RATE_LO_LSB]} : q01_q;	// [R1]
	assign q23_d = wr_q23 ? {new_w[`SWBPC_RATE_HI_MSB:`SWBPC_RATE_HI_LSB],
		new_w[`SWBPC_RATE_LO_MSB:`SWBPC_RATE_LO_LSB]} : q23_q;	// [R1]

	// per port tag write, one loop
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_tag
			logic hit;	// this port's tag register written
			assign hit = do_write & (wsel == swbpc_pkg::swbpc_sel_t'(
				int'(swbpc_pkg::SWBPC_SEL_TAG0) + gp));
			assign tag_d[gp].prio = hit ?
				new_w[`SWBPC_PRIO_MSB:`SWBPC_PRIO_LSB] :
				tag_q[gp].prio;	// [R4]
			assign tag_d[gp].vid = hit ?
				new_w[`SWBPC_VID_MSB:`SWBPC_VID_LSB] :
				tag_q[gp].vid;	// [R5]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// drop counters, one per ingress port
	// red and yellow in one cycle are one packet and count once.
	// a drop in the cycle of the clearing read is not lost: the counter
	// restarts at one rather than zero, the event winning over the clear.
	// at all ones it holds instead of wrapping until software reads it.

	generate
		for (gp = 0; gp < 3; gp++) begin : g_drop
			logic inc;	// one packet dropped this cycle
			logic clr;	// software reads this counter now
			logic full;	// counter at its ceiling
			assign inc = red_drop[gp] | yellow_drop[gp];	// [R6]
			assign clr = ar_hs & (rsel == swbpc_pkg::swbpc_sel_t'(
				int'(swbpc_pkg::SWBPC_SEL_DROP0) + gp));
			assign full = (drop_q[gp] == `SWBPC_DROP_MAX);
			// a drop in the read cycle is kept as the new count
			assign drop_d[gp] =
				clr ? {31'h0000_0000, inc} :		// [R7]
				(inc & !full) ? drop_q[gp] + 32'h0000_0001 :	// [R6]
				drop_q[gp];				// [R8]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// read mux

	logic [31:0] rd_word;	// data for the address being read
	logic        rd_bad;	// unmapped read

	// the word is taken at the address handshake, so a counter's value
	// and its clear belong to the same edge and no drop falls between.
	// reserved bits read zero [R9]
	always_comb begin
		rd_bad = 1'b0;
		case (rsel)
			swbpc_pkg::SWBPC_SEL_Q01:   rd_word = {6'h00, q01_q};
			swbpc_pkg::SWBPC_SEL_Q23:   rd_word = {6'h00, q23_q};
			swbpc_pkg::SWBPC_SEL_TAG0:  rd_word = {17'h0_0000, tag_q[0]};
			swbpc_pkg::SWBPC_SEL_TAG1:  rd_word = {17'h0_0000, tag_q[1]};
			swbpc_pkg::SWBPC_SEL_TAG2:  rd_word = {17'h0_0000, tag_q[2]};
			swbpc_pkg::SWBPC_SEL_DROP0: rd_word = drop_q[0];	// [R7]
			swbpc_pkg::SWBPC_SEL_DROP1: rd_word = drop_q[1];	// [R7]
			swbpc_pkg::SWBPC_SEL_DROP2: rd_word = drop_q[2];	// [R7]
			default: begin
				rd_word = 32'h0000_0000;	// unmapped
				rd_bad  = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// write channel registers

	// hazard: the answer may follow only once both halves are held;
	// do_write lasts one cycle, since bvalid rises at the next edge and
	// closes it again.
	// address and data held until the response is taken
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awaddr_q      <= 16'h0000;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
		end else begin
			if (aw_hs) begin
				s_axi_awready <= 1'b0;	// one write at a time
				awaddr_q      <= s_axi_awaddr;
			end else if (b_hs) begin
				s_axi_awready <= 1'b1;
			end
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end else if (b_hs) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// an unmapped address still gets its answer, flagged as an error,
	// so a master never waits on a write that went nowhere.
	// response one cycle after both halves are held
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SWBPC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_bad ? `SWBPC_RESP_SLVERR :
				`SWBPC_RESP_OKAY;
		end else if (b_hs) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read channel registers

	// data captured at the address edge, held until taken
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SWBPC_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_bad ? `SWBPC_RESP_SLVERR :
				`SWBPC_RESP_OKAY;
		end else if (r_hs) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration and counter registers

	// all fields and counters clear at reset [R9]
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q01_q  <= {`SWBPC_RATE_RST, `SWBPC_RATE_RST};
			q23_q  <= {`SWBPC_RATE_RST, `SWBPC_RATE_RST};
			tag_q  <= {3{`SWBPC_PRIO_RST, `SWBPC_VID_RST}};
			drop_q <= {3{`SWBPC_DROP_RST}};
		end else begin
			q01_q  <= q01_d;
			q23_q  <= q23_d;
			tag_q  <= tag_d;
			drop_q <= drop_d;
		end
	end

	// default tags leave straight from their registers
	assign port_default_tag = tag_q;	// [R4] [R5]

	////////////////////////////////////////////////////////////////////
	// port 2 egress pacing

	logic [3:0][12:0] qrate;	// rate code per queue
	assign qrate = {q23_q.hi, q23_q.lo, q01_q.hi, q01_q.lo};

	// the rate fields feed the pacers live; a new code takes effect at
	// the next byte sent, since the interval loads only on a byte.
	// the per-queue enables come from configuration held elsewhere.
	// one pacer per priority queue
	generate
		for (gp = 0; gp < 4; gp++) begin : g_pace
			swbpc_pacer u_pacer (
				.clk       (clk),
				.rst_b     (rst_b),
				.rate      (qrate[gp]),		// [R2]
				.enable    (p2_pace_enable[gp]),	// [R3]
				.byte_sent (p2_byte_sent[gp]),
				.may_send  (p2_may_send[gp])
			);
		end
	endgenerate

endmodule // swbpc_port_cfg
`default_nettype wire

// >>> swbpc_port_cfg_props.sv
// checker for the port config bank, bound to its top-level ports
// assumes one clock domain and rst_b asynchronous, active low
`timescale 1ns/10ps
`default_nettype none
`include "swbpc_regs.svh"

module swbpc_port_cfg_chk (
	input wire logic                   clk,
	input wire logic                   rst_b,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic                   s_axi_bvalid,
	input wire logic [15:0]            s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic                   s_axi_rvalid,
	input wire logic [3:0]             p2_pace_enable,
	input wire logic [3:0]             p2_byte_sent,
	input wire logic [3:0]             p2_may_send,
	input wire swbpc_pkg::swbpc_tag_t [2:0] port_default_tag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////
	logic [13:0] ridx_q;	// word index of the open read
	// latch the index when a read address is taken
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) ridx_q <= 14'h0000;
		else if (s_axi_arvalid && s_axi_arready)
			ridx_q <= s_axi_araddr[15:2];
	end
	wire rate_sel = (ridx_q == `SWBPC_IDX_P2_Q01_RATE) ||
		(ridx_q == `SWBPC_IDX_P2_Q23_RATE);
	wire tag_sel = (ridx_q >= `SWBPC_IDX_HOST_TAG) &&
		(ridx_q <= `SWBPC_IDX_P2_TAG);

	////////////////////////////////////////////////////////////////////
	// write taken in one cycle, answer two edges later
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_wr_resp; s_wr_both |=> s_b_wait; endproperty
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_rate_rsvd; s_axi_rvalid && rate_sel |->
		s_axi_rdata[31:26] == 6'h00;
	endproperty
	property p_tag_rsvd; s_axi_rvalid && tag_sel |->
		s_axi_rdata[31:15] == 17'h0_0000;
	endproperty
	property p_tag_when; !$stable(port_default_tag) |-> $rose(s_axi_bvalid);
	endproperty
	property p_pace_drop; (p2_pace_enable & p2_byte_sent) != 4'h0 |=>
		(p2_may_send & $past(p2_byte_sent) & $past(p2_pace_enable)) == 4'h0;
	endproperty
	property p_pace_off; p2_pace_enable != 4'hf |=>
		(p2_may_send | $past(p2_pace_enable)) == 4'hf;
	endproperty

	a_wr_resp: assert property (p_wr_resp) else $error("late write answer");
	a_rd_lat: assert property (p_rd_lat) else $error("late read answer");
	a_aw_block: assert property (p_aw_block) else $error("write ready open");
	a_ar_block: assert property (p_ar_block) else $error("read ready open");
	a_rate_rsvd: assert property (p_rate_rsvd) else $error("rate rsvd");
	a_tag_rsvd: assert property (p_tag_rsvd) else $error("tag rsvd");
	a_tag_when: assert property (p_tag_when) else $error("tag moved");
	a_pace_drop: assert property (p_pace_drop) else $error("no gap");
	a_pace_off: assert property (p_pace_off) else $error("gated");
endmodule // swbpc_port_cfg_chk

bind swbpc_port_cfg swbpc_port_cfg_chk u_chk (.clk(clk), .rst_b(rst_b),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.p2_pace_enable(p2_pace_enable), .p2_byte_sent(p2_byte_sent),
	.p2_may_send(p2_may_send), .port_default_tag(port_default_tag));
`default_nettype wire

// >>> swbpc_regs.svh
// register offsets, field positions, reset values and pacing timing
// assumes a 32-bit word register bus; byte address is four times index
`ifndef SWBPC_REGS_SVH
`define SWBPC_REGS_SVH

// register indices; byte address = index * 4
`define SWBPC_IDX_P2_Q01_RATE   14'h1c11
`define SWBPC_IDX_P2_Q23_RATE   14'h1c12
`define SWBPC_IDX_HOST_TAG      14'h1c13
`define SWBPC_IDX_P1_TAG        14'h1c14
`define SWBPC_IDX_P2_TAG        14'h1c15
`define SWBPC_IDX_HOST_DROP     14'h1c16
`define SWBPC_IDX_P1_DROP       14'h1c17
`define SWBPC_IDX_P2_DROP       14'h1c18

// egress rate fields: odd queue high, even queue low
`define SWBPC_RATE_HI_MSB       25
`define SWBPC_RATE_HI_LSB       13
`define SWBPC_RATE_LO_MSB       12
`define SWBPC_RATE_LO_LSB       0

// default tag fields
`define SWBPC_PRIO_MSB          14
`define SWBPC_PRIO_LSB          12
`define SWBPC_VID_MSB           11
`define SWBPC_VID_LSB           0

// reset values
`define SWBPC_RATE_RST          13'h0000
`define SWBPC_PRIO_RST          3'h0
`define SWBPC_VID_RST           12'h000
`define SWBPC_DROP_RST          32'h0000_0000
`define SWBPC_DROP_MAX          32'hffff_ffff

// pacing time unit per byte and clock period
`define SWBPC_PACE_UNIT_NS      20
`define SWBPC_CLK_PERIOD_NS     10
`define SWBPC_PACE_UNIT_CYC     (`SWBPC_PACE_UNIT_NS / `SWBPC_CLK_PERIOD_NS)

// axi responses
`define SWBPC_RESP_OKAY         2'h0
`define SWBPC_RESP_SLVERR       2'h2

`endif

// >>> tb_top.sv
// testbench for the port config bank: bus, tags, pacing, drop counts
// assumes the design, its package, header and checker compile first
`timescale 1ns/10ps
`default_nettype none
`include "swbpc_regs.svh"
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %h got %h", nm, e, a); end end

module tb_top;
	logic clk, rst_b, aw_vld, aw_rdy, w_vld, w_rdy, b_vld, b_rdy;
	logic ar_vld, ar_rdy, r_vld, r_rdy;
	logic [15:0] aw_addr, ar_addr;	// byte addresses
	logic [31:0] w_data, r_data, d, rate;
	logic [3:0] w_strb, pace_en, byte_sent, may_send;
	logic [1:0] b_resp, r_resp, be;
	logic [2:0] red, yel;	// drop pulses per port
	logic [33:0] re;	// expected read data and response
	logic [33:0] rq[$];	// notes of expected reads
	logic [1:0] bq[$];	// notes of expected write answers
	logic [12:0] r[4];	// queue rate codes
	logic [13:0] k;
	logic [1:0] c;
	int num_errors = 0, compares = 0, n, j, q;
	swbpc_pkg::swbpc_tag_t [2:0] dtag;

	swbpc_port_cfg dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(aw_addr),
		.s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy), .s_axi_wdata(w_data),
		.s_axi_wstrb(w_strb), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_rdy),
		.s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
		.s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
		.s_axi_rready(r_rdy), .p2_pace_enable(pace_en),
		.p2_byte_sent(byte_sent), .p2_may_send(may_send),
		.port_default_tag(dtag), .red_drop(red), .yellow_drop(yel));

	////////////////////////////////////////////////////////////////////
	// free-running 100 mhz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// byte address of a word index
	function automatic logic [15:0] ba(input logic [13:0] i);
		return {i, 2'b00};
	endfunction

	// one write, address and data offered together
	task automatic wr(input logic [15:0] a, input logic [31:0] v,
		input logic [3:0] s, input logic [1:0] rsp);
		logic aw_done, w_done;
		@(posedge clk);
		bq.push_back(rsp);
		aw_addr <= a; w_data <= v; w_strb <= s;
		aw_vld <= 1'b1; w_vld <= 1'b1; b_rdy <= 1'b1;
		aw_done = 1'b0; w_done = 1'b0;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (aw_vld && aw_rdy) begin aw_vld <= 1'b0; aw_done = 1'b1; end
			if (w_vld && w_rdy) begin w_vld <= 1'b0; w_done = 1'b1; end
		end
		do @(posedge clk); while (b_vld !== 1'b1);
		b_rdy <= 1'b0;
	endtask

	// one read, expectation noted for the monitor
	task automatic rd(input logic [15:0] a, input logic [31:0] v,
		input logic [1:0] rsp);
		@(posedge clk);
		rq.push_back({v, rsp});
		ar_addr <= a; ar_vld <= 1'b1; r_rdy <= 1'b1;
		do @(posedge clk); while (ar_rdy !== 1'b1);
		ar_vld <= 1'b0;
		do @(posedge clk); while (r_vld !== 1'b1);
		r_rdy <= 1'b0;
	endtask

	// monitor: compare each answer with the oldest note
	always @(posedge clk) begin
		if (r_vld && r_rdy) begin
			re = rq.pop_front();
			`CHK("rdata", re[33:2], r_data)
			`CHK("rresp", re[1:0], r_resp)
		end
		if (b_vld && b_rdy) begin
			be = bq.pop_front();
			`CHK("bresp", be, b_resp)
		end
	end

	task automatic complete_run;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b, aw_vld, w_vld, b_rdy, ar_vld, r_rdy} = 6'h00;
		{aw_addr, ar_addr, w_data, w_strb} = 68'h0;
		{pace_en, byte_sent, red, yel} = 14'h0000;
		void'($urandom(32'h577479f1));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		// reset values of every register and output
		for (k = `SWBPC_IDX_P2_Q01_RATE; k <= `SWBPC_IDX_P2_DROP; k++)
			rd(ba(k), 32'h0000_0000, `SWBPC_RESP_OKAY);
		`CHK("tag_rst", 45'h0, dtag)
		`CHK("may_rst", 4'hf, may_send)
		// rate fields, full word then one byte lane
		rate = $urandom;
		wr(ba(`SWBPC_IDX_P2_Q01_RATE), rate, 4'hf, `SWBPC_RESP_OKAY);
		rd(ba(`SWBPC_IDX_P2_Q01_RATE), rate & 32'h03ff_ffff, 2'h0);
		d = $urandom;
		wr(ba(`SWBPC_IDX_P2_Q01_RATE), d, 4'b0001, `SWBPC_RESP_OKAY);
		rd(ba(`SWBPC_IDX_P2_Q01_RATE), {rate[31:8], d[7:0]} & 32'h03ff_ffff,
			`SWBPC_RESP_OKAY);
		// default tags of all three ports
		for (q = 0; q < 3; q++) begin
			d = $urandom;
			k = `SWBPC_IDX_HOST_TAG + q[13:0];
			wr(ba(k), d, 4'hf, `SWBPC_RESP_OKAY);
			rd(ba(k), d & 32'h0000_7fff, `SWBPC_RESP_OKAY);
			`CHK("tag_out", d[14:0], dtag[q])
		end
		// unmapped places answer with an error
		wr(16'h7064, $urandom, 4'hf, `SWBPC_RESP_SLVERR);
		rd(16'h7040, 32'h0000_0000, `SWBPC_RESP_SLVERR);
		// drop counters: red, yellow or both in one cycle count once
		for (q = 0; q < 3; q++) begin
			k = `SWBPC_IDX_HOST_DROP + q[13:0];
			wr(ba(k), 32'hffff_ffff, 4'hf, `SWBPC_RESP_OKAY);
			n = 1 + $urandom % 12;
			for (j = 0; j < n; j++) begin
				@(posedge clk);
				c = 2'(1 + $urandom % 3);
				red[q] <= c[0]; yel[q] <= c[1];
				@(posedge clk);
				red <= 3'h0; yel <= 3'h0;
			end
			// a drop at the clearing read's address edge survives it
			fork
				rd(ba(k), 32'(n), `SWBPC_RESP_OKAY);
				begin
					@(posedge clk);
					red[q] <= 1'b1;
					@(posedge clk);
					red[q] <= 1'b0;
				end
			join
			rd(ba(k), 32'h0000_0001, `SWBPC_RESP_OKAY);
			rd(ba(k), 32'h0000_0000, `SWBPC_RESP_OKAY);
		end
		// pacing gap per queue, shortest and longest codes included
		for (q = 0; q < 4; q++) r[q] = 13'($urandom % 16);
		r[0] = 13'h0000;
		r[3] = 13'h1fff;
		wr(ba(`SWBPC_IDX_P2_Q01_RATE), {6'h00, r[1], r[0]}, 4'hf, 2'h0);
		wr(ba(`SWBPC_IDX_P2_Q23_RATE), {6'h00, r[3], r[2]}, 4'hf, 2'h0);
		for (q = 0; q < 4; q++) begin
			@(posedge clk);
			pace_en[q] <= 1'b1; byte_sent[q] <= 1'b1;
			@(posedge clk);
			byte_sent[q] <= 1'b0;
			#1 `CHK("pace_lo", 1'b0, may_send[q])
			n = 1;
			while (may_send[q] !== 1'b1 && n < 20000) begin
				@(posedge clk);
				n++;
				#1;
			end
			`CHK("pace_gap", (r[q] + 1) * 2, n)
			@(posedge clk);
			pace_en[q] <= 1'b0; byte_sent[q] <= 1'b1;
			@(posedge clk);
			byte_sent[q] <= 1'b0;
			#1 `CHK("pace_off", 1'b1, may_send[q])
		end
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
